// file: verilog/adc_ref_clock_and_code_format.sv
// configuration side of the converter: reference, master clock, code format
// assumes host writes mode/setup/filter words as strobed ports; one clock
`timescale 1ns/1ps
`default_nettype none
module adc_ref_clock_and_code_format (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_mode_we,
	input  wire logic [15:0] i_mode_wdata,
	input  wire logic        i_setup_we,
	input  wire logic [15:0] i_setup_wdata,
	input  wire logic        i_filter_we,
	input  wire logic [15:0] i_filter_wdata,
	input  wire logic        i_osc,
	input  wire logic        i_crystal_input_pin,
	input  wire logic        i_clock_io_pin,
	input  wire logic        i_sample_valid,
	input  wire logic [23:0] i_sample,
	output logic      [15:0] o_mode,
	output logic      [15:0] o_setup,
	output logic      [15:0] o_filter,
	output logic      [1:0]  o_reference_source_select,
	output logic             o_reference_output_pin_en,
	output logic             o_clock_io_pin_out,
	output logic             o_clock_io_pin_oe,
	output logic             o_mclk,
	output logic      [1:0]  o_clk_state,
	output logic             o_direct_decimation_map,
	output logic      [14:0] o_decimation,
	output logic      [23:0] o_code,
	output logic             o_code_valid
);
	logic [15:0]             mode;
	logic [15:0]             setup;
	logic [15:0]             filter;
	adc_cfg_pkg::clk_state_t clk_state;
	adc_cfg_pkg::clk_state_t next_clk_state;
	adc_cfg_pkg::mode_cfg_t  mode_cfg;
	adc_cfg_pkg::setup_cfg_t setup_cfg;
	logic                    osc_mclk;
	logic                    xtal_mclk;

	function automatic adc_cfg_pkg::clk_state_t decode_clk(input logic [1:0] sel);
		case (sel)
			adc_cfg_pkg::CLK_CRYSTAL:   decode_clk = adc_cfg_pkg::CLKST_XTAL;
			adc_cfg_pkg::CLK_EXT_CLOCK: decode_clk = adc_cfg_pkg::CLKST_EXT;
			default:                    decode_clk = adc_cfg_pkg::CLKST_INT;
		endcase
	endfunction

	// config registers, all cleared: external ref, ref off, internal osc
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mode   <= adc_cfg_pkg::MODE_RESET; // RULE_08 RULE_11
			setup  <= adc_cfg_pkg::SETUP_RESET; // RULE_06
			filter <= adc_cfg_pkg::FILTER_RESET;
		end else begin
			if (i_mode_we)
				mode <= i_mode_wdata;
			if (i_setup_we)
				setup <= i_setup_wdata;
			if (i_filter_we)
				filter <= i_filter_wdata;
		end
	end

	assign mode_cfg.ref_int_en = mode[adc_cfg_pkg::REF_EN_BIT]; // RULE_07
	assign mode_cfg.clk_sel    = mode[adc_cfg_pkg::CLK_SEL_LSB +: 2]; // RULE_10
	assign setup_cfg.ref_sel   = setup[adc_cfg_pkg::REF_SEL_LSB +: 2]; // RULE_05
	assign setup_cfg.bipolar   = setup[adc_cfg_pkg::BIPOLAR_BIT];
	assign next_clk_state      = decode_clk(mode_cfg.clk_sel); // RULE_19

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			clk_state <= adc_cfg_pkg::CLKST_INT; // RULE_11
		else
			clk_state <= next_clk_state;
	end

	mclk_divider u_osc_div (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_src   (i_osc),
		.o_mclk  (osc_mclk)
	);

	mclk_divider u_xtal_div (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_src   (i_crystal_input_pin),
		.o_mclk  (xtal_mclk)
	);

	// master clock mux; rates downstream follow whichever source is chosen
	wire ext_sel  = clk_state == adc_cfg_pkg::CLKST_EXT;
	wire xtal_sel = clk_state == adc_cfg_pkg::CLKST_XTAL;
	wire mclk_mux = ext_sel ? i_clock_io_pin : (xtal_sel ? xtal_mclk : osc_mclk); // RULE_13 RULE_14 RULE_16

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_mclk             <= 1'b0;
			o_clock_io_pin_out <= 1'b0;
		end else begin
			o_mclk             <= mclk_mux; // RULE_12
			o_clock_io_pin_out <= i_osc; // RULE_15
		end
	end

	// pin driven only in internal-osc-out mode; crystal/ext keep it an input
	assign o_clock_io_pin_oe = mode_cfg.clk_sel == adc_cfg_pkg::CLK_INT_OSC_OUT; // RULE_15

	assign o_mode                    = mode;
	assign o_setup                   = setup;
	assign o_filter                  = filter;
	assign o_reference_source_select = setup_cfg.ref_sel; // RULE_05
	assign o_reference_output_pin_en = mode_cfg.ref_int_en; // RULE_07 RULE_09
	assign o_clk_state               = clk_state;
	assign o_direct_decimation_map   = filter[adc_cfg_pkg::MAP_BIT]; // RULE_18
	assign o_decimation              = filter[adc_cfg_pkg::MAP_BIT] ? filter[14:0] : adc_cfg_pkg::DEFAULT_DECIM; // RULE_18

	code_formatter u_fmt (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_valid   (i_sample_valid),
		.i_bipolar (setup_cfg.bipolar),
		.i_sample  (i_sample),
		.o_code    (o_code),
		.o_valid   (o_code_valid)
	);

	// defaults after reset
	ref_reset_a: assert property (@(posedge i_clk) // RULE_08
		!i_rst_n
		|=> !o_reference_output_pin_en && o_reference_source_select == adc_cfg_pkg::REF_EXTERNAL)
		else $error("reference not default after reset");
	clk_reset_a: assert property (@(posedge i_clk) // RULE_11
		!i_rst_n
		|=> clk_state == adc_cfg_pkg::CLKST_INT)
		else $error("clock source not internal after reset");
	setup_reset_a: assert property (@(posedge i_clk) // RULE_06
		!i_rst_n
		|=> o_setup == adc_cfg_pkg::SETUP_RESET && o_mode == adc_cfg_pkg::MODE_RESET)
		else $error("config words not cleared by reset");
	mclk_reset_a: assert property (@(posedge i_clk) // RULE_11
		!i_rst_n
		|=> !o_mclk && !o_clock_io_pin_out)
		else $error("clock outputs not cleared by reset");

	// register words
	mode_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_10
		i_mode_we
		|=> o_mode == $past(i_mode_wdata))
		else $error("mode word not written");
	setup_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		i_setup_we
		|=> o_setup == $past(i_setup_wdata))
		else $error("setup word not written");
	filter_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_18
		i_filter_we
		|=> o_filter == $past(i_filter_wdata))
		else $error("filter word not written");
	mode_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_10
		!i_mode_we
		|=> o_mode == $past(o_mode))
		else $error("mode word changed without write");
	setup_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		!i_setup_we
		|=> o_setup == $past(o_setup))
		else $error("setup word changed without write");
	filter_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_18
		!i_filter_we
		|=> o_filter == $past(o_filter))
		else $error("filter word changed without write");

	// master clock selection and routing
	clk_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_10
		i_mode_we && i_mode_wdata[3:2] == adc_cfg_pkg::CLK_EXT_CLOCK
		|=> ##1 ext_sel)
		else $error("external clock not selected");
	clk_crystal_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_13
		o_mode[3:2] == adc_cfg_pkg::CLK_CRYSTAL
		|=> o_clk_state == adc_cfg_pkg::CLKST_XTAL)
		else $error("crystal not selected");
	clk_ext_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_16
		o_mode[3:2] == adc_cfg_pkg::CLK_EXT_CLOCK
		|=> o_clk_state == adc_cfg_pkg::CLKST_EXT)
		else $error("external clock state missing");
	clk_int_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_11
		o_mode[3:2] == adc_cfg_pkg::CLK_INT_OSC
		|=> o_clk_state == adc_cfg_pkg::CLKST_INT)
		else $error("internal oscillator not selected");
	clk_int_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_15
		o_mode[3:2] == adc_cfg_pkg::CLK_INT_OSC_OUT
		|=> o_clk_state == adc_cfg_pkg::CLKST_INT)
		else $error("oscillator output mode not internal");
	clk_code_legal_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_19
		1'b1
		|-> o_clk_state != 2'h2)
		else $error("illegal clock state code");
	clk_onehot_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_10
		1'b1
		|-> !(ext_sel && xtal_sel))
		else $error("two clock sources selected");
	ext_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_16
		ext_sel
		|=> o_mclk == $past(i_clock_io_pin))
		else $error("external clock not routed");
	xtal_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_13
		xtal_sel
		|=> o_mclk == $past(xtal_mclk))
		else $error("crystal clock not routed");
	osc_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_12
		clk_state == adc_cfg_pkg::CLKST_INT
		|=> o_mclk == $past(osc_mclk))
		else $error("oscillator clock not routed");
	pin_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_15
		1'b1
		|=> o_clock_io_pin_out == $past(i_osc))
		else $error("clock pin output not oscillator");
	osc_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_15
		i_mode_we
		|=> o_clock_io_pin_oe == ($past(i_mode_wdata[3:2]) == adc_cfg_pkg::CLK_INT_OSC_OUT))
		else $error("clock pin driven in wrong mode");
	oe_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_16
		o_mode[3:2] != adc_cfg_pkg::CLK_INT_OSC_OUT
		|-> !o_clock_io_pin_oe)
		else $error("clock pin driven while input");
	oe_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_15
		o_mode[3:2] == adc_cfg_pkg::CLK_INT_OSC_OUT
		|-> o_clock_io_pin_oe)
		else $error("clock pin not driven");

	// reference
	ref_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_07
		i_mode_we
		|=> o_reference_output_pin_en == $past(i_mode_wdata[15]))
		else $error("reference enable not taken");
	ref_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		i_setup_we
		|=> o_reference_source_select == $past(i_setup_wdata[5:4]))
		else $error("reference select not taken");
	ref_sel_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		1'b1
		|-> o_reference_source_select == o_setup[5:4])
		else $error("reference select not from setup");
	ref_en_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_07
		1'b1
		|-> o_reference_output_pin_en == o_mode[15])
		else $error("reference enable not from mode");
	ref_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_08
		!o_mode[15]
		|-> !o_reference_output_pin_en)
		else $error("reference on while disabled");
	supply_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		i_setup_we && i_setup_wdata[5:4] == adc_cfg_pkg::REF_SUPPLY
		|=> o_reference_source_select == adc_cfg_pkg::REF_SUPPLY)
		else $error("supply reference not selected");
	internal_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_05
		i_setup_we && i_setup_wdata[5:4] == adc_cfg_pkg::REF_INTERNAL
		|=> o_reference_source_select == adc_cfg_pkg::REF_INTERNAL)
		else $error("internal reference not selected");

	// filter decimation
	map_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_18
		i_filter_we && i_filter_wdata[15]
		|=> o_decimation == $past(i_filter_wdata[14:0]))
		else $error("direct decimation not applied");
	decim_default_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_18
		!o_filter[15]
		|-> o_decimation == adc_cfg_pkg::DEFAULT_DECIM && !o_direct_decimation_map)
		else $error("default decimation not used");
	decim_direct_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_18
		o_filter[15]
		|-> o_decimation == o_filter[14:0] && o_direct_decimation_map)
		else $error("direct decimation not used");

	// output code
	code_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_01
		!i_sample_valid
		|=> o_code == $past(o_code))
		else $error("code changed without sample");
	code_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_02
		!i_sample_valid
		|=> !o_code_valid)
		else $error("code valid without sample");
	bip_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_03
		i_sample_valid && o_setup[adc_cfg_pkg::BIPOLAR_BIT] && i_sample == 24'h7FFFFF
		|=> o_code == 24'hFFFFFF)
		else $error("bipolar positive full scale wrong");
	bip_negfull_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_04
		i_sample_valid && o_setup[adc_cfg_pkg::BIPOLAR_BIT] && i_sample == 24'h800000
		|=> o_code == 24'h000000)
		else $error("bipolar negative full scale wrong");
	uni_mid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_01
		i_sample_valid && !o_setup[adc_cfg_pkg::BIPOLAR_BIT] && i_sample == 24'h800000
		|=> o_code == adc_cfg_pkg::MIDSCALE)
		else $error("unipolar midscale wrong");
	uni_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_02
		i_sample_valid && !o_setup[adc_cfg_pkg::BIPOLAR_BIT] && i_sample == 24'h000000
		|=> o_code == 24'h000000)
		else $error("unipolar zero wrong");

	cov_xtal_c: cover property (@(posedge i_clk) xtal_sel && o_mclk);
	cov_ext_c: cover property (@(posedge i_clk) ext_sel);
	cov_refen_c: cover property (@(posedge i_clk) o_reference_output_pin_en);
	cov_bipolar_c: cover property (@(posedge i_clk) o_code_valid && o_setup[adc_cfg_pkg::BIPOLAR_BIT]);
	cov_direct_c: cover property (@(posedge i_clk) o_direct_decimation_map);
endmodule
`default_nettype wire

// file: verilog/adc_cfg_pkg.sv
// constants and types for the reference, clock and code format block
// assumes a single 20 MHz system clock and synchronous active-low reset
// Summary of operation
// RULE_01 - unipolar results are straight binary: zero, midscale, full scale.
// RULE_02 - unipolar code equals two to the 24 times input tenth over reference.
// RULE_03 - bipolar results are offset binary around midscale.
// RULE_04 - bipolar code equals two to 23 times one plus scaled input.
// RULE_05 - setup field bits 5 to 4 choose the reference source.
// RULE_06 - external reference selected after power-up.
// RULE_07 - mode bit 15 enables internal reference onto reference output pin.
// RULE_08 - internal reference enable resets to off.
// RULE_09 - host keeps internal reference off when unused.
// RULE_10 - mode bits 3 to 2 choose the master clock source.
// RULE_11 - internal oscillator is the clock source after reset.
// RULE_12 - internal 16 MHz oscillator divided by eight to 2 MHz.
// RULE_13 - crystal 16 MHz likewise divided to 2 MHz.
// RULE_14 - data rates scale with the master clock rate.
// RULE_15 - internal oscillator clock may be driven out on clock io pin.
// RULE_16 - external clock source taken from clock io pin to modulator.
// RULE_17 - host withholds serial clocks until crystal has started.
// RULE_18 - direct decimation map bit lets software set sinc3 decimation.
// RULE_19 - field encodings are parameters; defaults external ref, internal osc.
package adc_cfg_pkg;
	localparam int          CODE_W          = 24;
	localparam int          REF_SEL_LSB     = 4;
	localparam int          REF_EN_BIT      = 15;
	localparam int          CLK_SEL_LSB     = 2;
	localparam int          MAP_BIT         = 15;
	localparam int          BIPOLAR_BIT     = 12;
	localparam logic [1:0]  REF_EXTERNAL    = 2'h0;
	localparam logic [1:0]  REF_SUPPLY      = 2'h1;
	localparam logic [1:0]  REF_INTERNAL    = 2'h2;
	localparam logic [1:0]  CLK_INT_OSC     = 2'h0;
	localparam logic [1:0]  CLK_INT_OSC_OUT = 2'h1;
	localparam logic [1:0]  CLK_EXT_CLOCK   = 2'h2;
	localparam logic [1:0]  CLK_CRYSTAL     = 2'h3;
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [15:0] SETUP_RESET     = 16'h0000;
	localparam logic [15:0] FILTER_RESET    = 16'h0000;
	localparam int          OSC_HZ          = 16000000;
	localparam int          MCLK_HZ         = 2000000;
	localparam int          DIV_RATIO       = OSC_HZ / MCLK_HZ;
	localparam logic [2:0]  DIV_HALF        = 3'(DIV_RATIO / 2 - 1);
	localparam logic [23:0] MIDSCALE        = 24'h800000;
	localparam logic [14:0] DEFAULT_DECIM   = 15'h0271;

	typedef enum logic [1:0] {
		CLKST_INT  = 2'b00,
		CLKST_XTAL = 2'b01,
		CLKST_EXT  = 2'b11
	} clk_state_t;

	typedef struct packed {
		logic        ref_int_en;
		logic [1:0]  clk_sel;
	} mode_cfg_t;

	typedef struct packed {
		logic        bipolar;
		logic [1:0]  ref_sel;
	} setup_cfg_t;
endpackage

// file: verilog/mclk_divider.sv
// divide-by-eight of a sampled 16 MHz source to the 2 MHz master clock
// assumes the source is sampled as a level in the system domain
`timescale 1ns/1ps
`default_nettype none
module mclk_divider (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_src,
	output logic      o_mclk
);
	logic       src_d;
	logic [2:0] cnt;
	wire        rise = i_src & ~src_d;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			src_d  <= 1'b0;
			cnt    <= 3'h0;
			o_mclk <= 1'b0;
		end else begin
			src_d <= i_src;
			if (rise) begin
				cnt <= (cnt == adc_cfg_pkg::DIV_HALF) ? 3'h0 : cnt + 3'h1; // RULE_12 RULE_13
				if (cnt == adc_cfg_pkg::DIV_HALF)
					o_mclk <= ~o_mclk;
			end
		end
	end

	mclk_toggle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_12
		rise && cnt == adc_cfg_pkg::DIV_HALF |=> o_mclk != $past(o_mclk))
		else $error("divider missed toggle");
endmodule
`default_nettype wire

// file: verilog/code_formatter.sv
// turns signed modulator result into unipolar or bipolar output code
// assumes the input is a two's complement fraction of full scale
`timescale 1ns/1ps
`default_nettype none
module code_formatter (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_valid,
	input  wire logic        i_bipolar,
	input  wire logic [23:0] i_sample,
	output logic      [23:0] o_code,
	output logic             o_valid
);
	// bipolar: flip msb turns two's complement into offset binary
	wire [23:0] bip_code = i_sample ^ adc_cfg_pkg::MIDSCALE; // RULE_03 RULE_04
	// unipolar: sample is already straight binary magnitude
	wire [23:0] uni_code = i_sample; // RULE_01 RULE_02
	wire [23:0] next_code = i_bipolar ? bip_code : uni_code;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_code  <= 24'h000000;
			o_valid <= 1'b0;
		end else begin
			o_valid <= i_valid;
			if (i_valid)
				o_code <= next_code;
		end
	end

	bipolar_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_03
		i_valid && i_bipolar && i_sample == 24'h000000 |=> o_code == 24'h800000)
		else $error("bipolar zero not midscale");
	unipolar_pass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_01
		i_valid && !i_bipolar |=> o_code == $past(i_sample))
		else $error("unipolar code altered");
	bipolar_msb_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_04
		i_valid && i_bipolar |=> o_code[23] == !$past(i_sample[23]))
		else $error("bipolar msb wrong");
	fmt_valid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE_02
		i_valid |=> o_valid)
		else $error("valid lost");
endmodule
`default_nettype wire

// file: bench/clock_sources.sv
// free-running stand-ins for the oscillator, the crystal and the external clock pin
// assumes the system clock is much faster than each source
`timescale 1ns/1ps
`default_nettype none
module clock_sources (
	input  wire logic i_clk,
	output logic      o_osc,
	output logic      o_xtal,
	output logic      o_ext
);
	int n = 0;

	// periods of 4, 6 and 10 system cycles keep each source slower than half the clock
	always_ff @(posedge i_clk) begin
		n <= n + 1;
		o_osc <= (n % 4) < 2;
		o_xtal <= (n % 6) < 3;
		o_ext <= (n % 10) < 5;
	end
endmodule
`default_nettype wire

// file: bench/adc_ref_clock_and_code_format_tb_top.sv
// self-checking bench for the reference, master clock and code format block
// assumes the clock source model beside it; write, sample and reset inputs change on the falling edge, the source outputs on the rising edge
`timescale 1ns/1ps
`default_nettype none
module adc_ref_clock_and_code_format_tb_top;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_mode_we = 1'b0;
	logic [15:0] i_mode_wdata = 16'h0000;
	logic        i_setup_we = 1'b0;
	logic [15:0] i_setup_wdata = 16'h0000;
	logic        i_filter_we = 1'b0;
	logic [15:0] i_filter_wdata = 16'h0000;
	logic        i_osc, i_crystal_input_pin, i_clock_io_pin;
	logic        i_sample_valid = 1'b0;
	logic [23:0] i_sample = 24'h000000;
	logic [15:0] o_mode, o_setup, o_filter;
	logic [1:0]  o_reference_source_select, o_clk_state;
	logic        o_reference_output_pin_en, o_clock_io_pin_out, o_clock_io_pin_oe, o_mclk;
	logic        o_direct_decimation_map, o_code_valid;
	logic [14:0] o_decimation;
	logic [23:0] o_code;
	int          err_total = 0;
	int          samples_checked = 0;

	clock_sources i_clock_sources (.i_clk, .o_osc(i_osc), .o_xtal(i_crystal_input_pin), .o_ext(i_clock_io_pin));

	adc_ref_clock_and_code_format i_adc_ref_clock_and_code_format (.i_clk, .i_rst_n, .i_mode_we, .i_mode_wdata,
		.i_setup_we, .i_setup_wdata, .i_filter_we, .i_filter_wdata, .i_osc, .i_crystal_input_pin,
		.i_clock_io_pin, .i_sample_valid, .i_sample, .o_mode, .o_setup, .o_filter, .o_reference_source_select,
		.o_reference_output_pin_en, .o_clock_io_pin_out, .o_clock_io_pin_oe, .o_mclk, .o_clk_state,
		.o_direct_decimation_map, .o_decimation, .o_code, .o_code_valid);

	initial begin
		forever #25 i_clk = ~i_clk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// which: 0 mode, 1 setup, 2 filter
	task automatic wr(input int which, input logic [15:0] d);
		@(negedge i_clk);
		i_mode_we = (which == 0);
		i_setup_we = (which == 1);
		i_filter_we = (which == 2);
		i_mode_wdata = d;
		i_setup_wdata = d;
		i_filter_wdata = d;
		@(negedge i_clk);
		i_mode_we = 1'b0;
		i_setup_we = 1'b0;
		i_filter_we = 1'b0;
	endtask

	// cycles between two successive master clock rises
	task automatic mclk_period(output int n);
		logic prev;
		int   rises;
		rises = 0;
		n = 0;
		prev = 1'b1;
		for (int k = 0; k < 400 && rises < 2; k++) begin
			@(negedge i_clk);
			if (rises == 1) n++;
			if (o_mclk === 1'b1 && prev === 1'b0) rises++;
			prev = o_mclk;
		end
		if (rises < 2) begin
			err_total++;
			report_and_stop();
		end
	endtask

	task automatic smp(input logic [23:0] s, input logic [23:0] exp);
		@(negedge i_clk);
		i_sample_valid = 1'b1;
		i_sample = s;
		@(negedge i_clk);
		i_sample_valid = 1'b0;
		chk({23'h0, o_code_valid}, 24'h000001);
		chk(o_code, exp);
	endtask

	task automatic t_reset();
		int p;
		chk({o_mode, o_setup[7:0]}, 24'h000000);
		chk({8'h00, o_filter}, 24'h000000);
		chk({22'h0, o_reference_source_select}, {22'h0, adc_cfg_pkg::REF_EXTERNAL});
		chk({22'h0, o_clk_state}, {22'h0, adc_cfg_pkg::CLKST_INT});
		chk({23'h0, o_reference_output_pin_en}, 24'h000000);
		mclk_period(p);
		chk(24'(p), 24'h000020);
		$display("reset test done");
	endtask

	task automatic t_clock();
		logic [1:0] sel[4] = '{adc_cfg_pkg::CLK_INT_OSC, adc_cfg_pkg::CLK_INT_OSC_OUT,
			adc_cfg_pkg::CLK_EXT_CLOCK, adc_cfg_pkg::CLK_CRYSTAL};
		logic [1:0] st[4] = '{adc_cfg_pkg::CLKST_INT, adc_cfg_pkg::CLKST_INT,
			adc_cfg_pkg::CLKST_EXT, adc_cfg_pkg::CLKST_XTAL};
		int per[4] = '{32, 32, 10, 48};
		int p;
		logic po;
		for (int i = 0; i < 4; i++) begin
			wr(0, 16'h8000 | (16'(sel[i]) << 2));
			chk({8'h00, o_mode}, 24'h008000 | (24'(sel[i]) << 2));
			chk({23'h0, o_reference_output_pin_en}, 24'h000001);
			@(negedge i_clk);
			chk({22'h0, o_clk_state}, {22'h0, st[i]});
			chk({23'h0, o_clock_io_pin_oe}, {23'h0, i == 1});
			po = i_osc;
			@(negedge i_clk);
			chk({23'h0, o_clock_io_pin_out}, {23'h0, po});
			// no writes while a newly chosen crystal settles
			repeat (100) @(negedge i_clk);
			mclk_period(p);
			chk(24'(p), 24'(per[i]));
		end
		wr(0, 16'h0000);
		chk({23'h0, o_reference_output_pin_en}, 24'h000000);
		$display("clock test done");
	endtask

	task automatic t_ref_filter();
		for (int r = 0; r < 3; r++) begin
			wr(1, 16'(r) << 4);
			chk({22'h0, o_reference_source_select}, 24'(r));
		end
		wr(2, 16'hFFFF);
		chk({8'h00, o_direct_decimation_map, o_decimation}, 24'h00FFFF);
		wr(2, 16'h7FFF);
		chk({8'h00, o_direct_decimation_map, o_decimation}, {9'h000, adc_cfg_pkg::DEFAULT_DECIM});
		$display("reference and filter test done");
	endtask

	task automatic t_code();
		wr(1, 16'h0000);
		smp(24'h000000, 24'h000000);
		smp(24'h800000, 24'h800000);
		smp(24'hFFFFFF, 24'hFFFFFF);
		wr(1, 16'h1000);
		smp(24'h800000, 24'h000000);
		smp(24'h000000, 24'h800000);
		smp(24'h7FFFFF, 24'hFFFFFF);
		$display("code format test done");
	endtask

	initial begin
		repeat (6) @(negedge i_clk);
		i_rst_n = 1'b1;
		t_reset();
		t_clock();
		t_ref_filter();
		t_code();
		report_and_stop();
	end
endmodule
`default_nettype wire
